/* File: ebpsb_consts.svh */
// Offsets, field positions, masks and reset values of the pin select bank
`ifndef EBPSB_CONSTS_SVH
`define EBPSB_CONSTS_SVH

`define EBPSB_ADDR_W 12
`define EBPSB_OFS_ENB 12'h000
`define EBPSB_OFS_ENA 12'h004
`define EBPSB_OFS_EFF 12'h008

`define EBPSB_ENB_MASK 32'h03ff_ffff
`define EBPSB_ENA_MASK 32'h0000_0003
`define EBPSB_ENB_RST 32'h0000_0000
`define EBPSB_ENA_RST 32'h0000_0000

`define EBPSB_B_RSVD_MSB 31
`define EBPSB_B_RSVD_LSB 26
`define EBPSB_B_RELOC 25
`define EBPSB_B_D15 24
`define EBPSB_B_DHI_MSB 24
`define EBPSB_B_DHI_LSB 17
`define EBPSB_B_D14_MSB 23
`define EBPSB_B_D_LSB 9
`define EBPSB_B_DLO_MSB 16
`define EBPSB_B_A_MSB 8
`define EBPSB_B_A_LSB 3
`define EBPSB_B_A1 2
`define EBPSB_B_CS0 1
`define EBPSB_B_ALE 0

`define EBPSB_A_COL_LO 0
`define EBPSB_A_COL_HI 1

`define EBPSB_RESP_OKAY 2'h0
`define EBPSB_RESP_SLVERR 2'h2

`endif

/* File: ebpsb_pkg.sv */
// Types shared by the pin select bank
`default_nettype none
package ebpsb_pkg;
   // One bit or value per user external bus pin of a relocation set
   typedef struct packed {
      logic [15:0] data;
      logic [7:1] addr;
      logic cs0;
      logic ale;
   } ebpsb_pins_t;

   typedef enum logic [1:0] {
      EBPSB_SEL_ENB,
      EBPSB_SEL_ENA,
      EBPSB_SEL_EFF,
      EBPSB_SEL_NONE
   } ebpsb_sel_t;
endpackage
`default_nettype wire

/* File: ebpsb_pad_set.sv */
// Registered pad drive for one relocation set of the user external bus
`default_nettype none
module ebpsb_pad_set (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic set_active,
   input wire ebpsb_pkg::ebpsb_pins_t ctl_out,
   input wire ebpsb_pkg::ebpsb_pins_t eff_oe,
   output ebpsb_pkg::ebpsb_pins_t pad_out,
   output ebpsb_pkg::ebpsb_pins_t pad_oe
);
   // Value passes untouched; only the enable is gated, one cycle late
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_out <= '0;
      end else begin
         pad_out <= ctl_out;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_oe <= '0;
      end else if (set_active) begin
         pad_oe <= eff_oe;
      end else begin
         pad_oe <= '0;
      end
   end
endmodule // ebpsb_pad_set
`default_nettype wire

/* File: ebpsb_bank.sv */
// Pin select bank for the user external bus, with AXI4-Lite registers
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`include "ebpsb_consts.svh"
`default_nettype none
module ebpsb_bank (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic standby_reset,
   input wire logic [`EBPSB_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`EBPSB_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ebpsb_pkg::ebpsb_pins_t ctl_out,
   output logic [15:0] ctl_data_in,
   output logic pin_relocation_select,
   output ebpsb_pkg::ebpsb_pins_t pad0_out,
   output ebpsb_pkg::ebpsb_pins_t pad0_oe,
   input wire logic [15:0] pad0_data_in,
   output ebpsb_pkg::ebpsb_pins_t pad1_out,
   output ebpsb_pkg::ebpsb_pins_t pad1_oe,
   input wire logic [15:0] pad1_data_in
);
   logic bus_rst;
   logic aw_take, w_take, ar_take, do_write;
   logic aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic [`EBPSB_ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_d, rvalid_d;
   logic [31:0] enb_q, ena_q, eff_word, rdata_d;
   logic [1:0] rresp_d;
   ebpsb_pkg::ebpsb_sel_t wr_sel, rd_sel, rd_sel_q;
   ebpsb_pkg::ebpsb_pins_t eff_oe;
   logic [15:0] data_in_sel;

   function automatic ebpsb_pkg::ebpsb_sel_t decode_sel(
      input logic [`EBPSB_ADDR_W-1:0] addr);
      unique case (addr)
         `EBPSB_OFS_ENB: decode_sel = ebpsb_pkg::EBPSB_SEL_ENB;
         `EBPSB_OFS_ENA: decode_sel = ebpsb_pkg::EBPSB_SEL_ENA;
         `EBPSB_OFS_EFF: decode_sel = ebpsb_pkg::EBPSB_SEL_EFF;
         default: decode_sel = ebpsb_pkg::EBPSB_SEL_NONE;
      endcase
   endfunction

   // Byte lanes merge into the old value; reserved bits always land as zero
   function automatic logic [31:0] merge_strb(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0] strb,
      input logic [31:0] mask);
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
      merge_strb = res & mask;
   endfunction

   // Standby reset only restarts the bus handshake, never the fields
   assign bus_rst = !aresetn || standby_reset;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_sel = decode_sel(aw_addr_q);
   assign rd_sel = decode_sel(s_axi_araddr);
   assign aw_held_d = (aw_held_q && !do_write) || aw_take;
   assign w_held_d = (w_held_q && !do_write) || w_take;
   assign bvalid_d = do_write || (s_axi_bvalid && !s_axi_bready);
   assign rvalid_d = ar_take || (s_axi_rvalid && !s_axi_rready);

   always_ff @(posedge aclk) begin
      if (bus_rst) begin
         aw_held_q <= 1'b0;
         s_axi_awready <= 1'b0;
      end else begin
         aw_held_q <= aw_held_d;
         s_axi_awready <= !aw_held_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (bus_rst) begin
         w_held_q <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         w_held_q <= w_held_d;
         s_axi_wready <= !w_held_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else begin
         if (aw_take) begin
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (bus_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `EBPSB_RESP_OKAY;
      end else begin
         s_axi_bvalid <= bvalid_d;
         if (do_write) begin
            if (wr_sel == ebpsb_pkg::EBPSB_SEL_ENB ||
                wr_sel == ebpsb_pkg::EBPSB_SEL_ENA) begin
               s_axi_bresp <= `EBPSB_RESP_OKAY;
            end else begin
               s_axi_bresp <= `EBPSB_RESP_SLVERR;
            end
         end
      end
   end

   // Only the full reset clears the fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enb_q <= `EBPSB_ENB_RST;
      end else if (do_write && wr_sel == ebpsb_pkg::EBPSB_SEL_ENB) begin
         enb_q <= merge_strb(enb_q, w_data_q, w_strb_q,
                             `EBPSB_ENB_MASK);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ena_q <= `EBPSB_ENA_RST;
      end else if (do_write && wr_sel == ebpsb_pkg::EBPSB_SEL_ENA) begin
         ena_q <= merge_strb(ena_q, w_data_q, w_strb_q, `EBPSB_ENA_MASK);
      end
   end

   // Collective controls win over the per-bit enables
   always_comb begin
      eff_oe.data[15:8] = enb_q[`EBPSB_B_DHI_MSB:`EBPSB_B_DHI_LSB];
      eff_oe.data[7:0] = enb_q[`EBPSB_B_DLO_MSB:`EBPSB_B_D_LSB];
      eff_oe.addr[7:2] = enb_q[`EBPSB_B_A_MSB:`EBPSB_B_A_LSB];
      eff_oe.addr[1] = enb_q[`EBPSB_B_A1];
      eff_oe.cs0 = enb_q[`EBPSB_B_CS0];
      eff_oe.ale = enb_q[`EBPSB_B_ALE];
      if (ena_q[`EBPSB_A_COL_HI]) begin
         eff_oe.data[15:8] = '1;
      end
      if (ena_q[`EBPSB_A_COL_LO]) begin
         eff_oe.data[7:0] = '1;
         eff_oe.addr = '1;
         eff_oe.cs0 = 1'b1;
      end
   end

   assign eff_word = {enb_q[`EBPSB_B_RSVD_MSB:`EBPSB_B_RELOC + 1],
                      enb_q[`EBPSB_B_RELOC], eff_oe};

   always_comb begin
      rdata_d = '0;
      rresp_d = `EBPSB_RESP_OKAY;
      unique case (rd_sel)
         ebpsb_pkg::EBPSB_SEL_ENB: rdata_d = enb_q;
         ebpsb_pkg::EBPSB_SEL_ENA: rdata_d = ena_q;
         ebpsb_pkg::EBPSB_SEL_EFF: rdata_d = eff_word;
         ebpsb_pkg::EBPSB_SEL_NONE: rresp_d = `EBPSB_RESP_SLVERR;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (bus_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `EBPSB_RESP_OKAY;
         rd_sel_q <= ebpsb_pkg::EBPSB_SEL_NONE;
      end else begin
         s_axi_rvalid <= rvalid_d;
         s_axi_arready <= !rvalid_d;
         if (ar_take) begin
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
            rd_sel_q <= rd_sel;
         end
      end
   end

   // Input path never depends on the drive enables
   assign data_in_sel = enb_q[`EBPSB_B_RELOC] ? pad1_data_in : pad0_data_in;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_data_in <= '0;
         pin_relocation_select <= 1'b0;
      end else begin
         ctl_data_in <= data_in_sel;
         pin_relocation_select <= enb_q[`EBPSB_B_RELOC];
      end
   end

   ebpsb_pad_set u_set0 (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_active(!enb_q[`EBPSB_B_RELOC]),
      .ctl_out(ctl_out),
      .eff_oe(eff_oe),
      .pad_out(pad0_out),
      .pad_oe(pad0_oe)
   );

   ebpsb_pad_set u_set1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_active(enb_q[`EBPSB_B_RELOC]),
      .ctl_out(ctl_out),
      .eff_oe(eff_oe),
      .pad_out(pad1_out),
      .pad_oe(pad1_oe)
   );

   property p_reserved_zero;
      @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && rd_sel_q == ebpsb_pkg::EBPSB_SEL_ENB |->
         s_axi_rdata[`EBPSB_B_RSVD_MSB:`EBPSB_B_RSVD_LSB] == '0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits read nonzero");

   property p_reloc_route;
      @(posedge aclk) disable iff (!aresetn)
      (pad1_oe != '0) |-> $past(enb_q[`EBPSB_B_RELOC]) &&
         (pad0_oe == '0);
   endproperty
   a_reloc_route: assert property (p_reloc_route)
      else $error("inactive pin set is driven");

   property p_data15;
      @(posedge aclk) disable iff (!aresetn)
      !ena_q[`EBPSB_A_COL_HI] && !enb_q[`EBPSB_B_RELOC] |=>
         pad0_oe.data[15] == $past(enb_q[`EBPSB_B_D15]);
   endproperty
   a_data15: assert property (p_data15)
      else $error("data line 15 enable wrong");

   property p_data_low;
      @(posedge aclk) disable iff (!aresetn)
      !ena_q[`EBPSB_A_COL_HI] && !ena_q[`EBPSB_A_COL_LO] &&
         !enb_q[`EBPSB_B_RELOC] |=>
         pad0_oe.data[14:0] ==
            $past(enb_q[`EBPSB_B_D14_MSB:`EBPSB_B_D_LSB]);
   endproperty
   a_data_low: assert property (p_data_low)
      else $error("data line 14..0 enables wrong");

   property p_input_path;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> ctl_data_in == $past(data_in_sel);
   endproperty
   a_input_path: assert property (p_input_path)
      else $error("pin input not routed to controller");

   property p_addr_oe;
      @(posedge aclk) disable iff (!aresetn)
      !ena_q[`EBPSB_A_COL_LO] && !enb_q[`EBPSB_B_RELOC] |=>
         pad0_oe.addr[7:2] == $past(enb_q[`EBPSB_B_A_MSB:`EBPSB_B_A_LSB]);
   endproperty
   a_addr_oe: assert property (p_addr_oe)
      else $error("address 7..2 enables wrong");

   property p_reset_clear;
      @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> enb_q == `EBPSB_ENB_RST && pad0_oe == '0 &&
         pad1_oe == '0;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("state not clear after reset");

   property p_readback;
      @(posedge aclk) disable iff (!aresetn)
      ar_take && !standby_reset && rd_sel == ebpsb_pkg::EBPSB_SEL_ENB |=>
         s_axi_rvalid && s_axi_rdata == $past(enb_q);
   endproperty
   a_readback: assert property (p_readback)
      else $error("readback differs from register");

   property p_write_store;
      @(posedge aclk) disable iff (!aresetn)
      do_write && wr_sel == ebpsb_pkg::EBPSB_SEL_ENB && w_strb_q == '1 |=>
         enb_q == ($past(w_data_q) & `EBPSB_ENB_MASK) ##1
         $stable(enb_q) || s_axi_bvalid;
   endproperty
   a_write_store: assert property (p_write_store)
      else $error("write not stored");

   property p_col_hi;
      @(posedge aclk) disable iff (!aresetn)
      ena_q[`EBPSB_A_COL_HI] && !enb_q[`EBPSB_B_RELOC] |=>
         pad0_oe.data[15:8] == '1;
   endproperty
   a_col_hi: assert property (p_col_hi)
      else $error("collective high-data override failed");

   property p_col_lo;
      @(posedge aclk) disable iff (!aresetn)
      ena_q[`EBPSB_A_COL_LO] && !enb_q[`EBPSB_B_RELOC] |=>
         pad0_oe.data[7:0] == '1 && pad0_oe.addr == '1 && pad0_oe.cs0 &&
         pad0_oe.ale == $past(enb_q[`EBPSB_B_ALE]);
   endproperty
   a_col_lo: assert property (p_col_lo)
      else $error("collective low-group override failed");

   property p_standby_keep;
      @(posedge aclk) disable iff (!aresetn)
      standby_reset |=> enb_q == $past(enb_q) && ena_q == $past(ena_q);
   endproperty
   a_standby_keep: assert property (p_standby_keep)
      else $error("standby reset disturbed fields");

   property p_low_bits;
      @(posedge aclk) disable iff (!aresetn)
      !ena_q[`EBPSB_A_COL_LO] && !enb_q[`EBPSB_B_RELOC] |=>
         pad0_oe.ale == $past(enb_q[`EBPSB_B_ALE]) &&
         pad0_oe.cs0 == $past(enb_q[`EBPSB_B_CS0]) &&
         pad0_oe.addr[1] == $past(enb_q[`EBPSB_B_A1]);
   endproperty
   a_low_bits: assert property (p_low_bits)
      else $error("low enable bits wrong");

   property p_value_pass;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> pad0_out == $past(ctl_out) && pad1_out == $past(ctl_out);
   endproperty
   a_value_pass: assert property (p_value_pass)
      else $error("pad value altered");
endmodule // ebpsb_bank
`default_nettype wire

/* File: ebpsb_far_model.sv */
// Far-side model: bus controller outputs and pin inputs of both sets
`default_nettype none
module ebpsb_far_model (
   input wire logic aclk,
   output ebpsb_pkg::ebpsb_pins_t ctl_out,
   output logic [15:0] pad0_data_in,
   output logic [15:0] pad1_data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Every value moves each cycle, so a stale or crossed path shows up
   // One process owns every output, so each has a single driver
   initial begin
      ctl_out = 25'h0000001;
      pad0_data_in = 16'h0000;
      pad1_data_in = 16'hffff;
      forever begin
         @(posedge aclk);
         ctl_out <= ~{ctl_out[23:0], ctl_out[24]};
         pad0_data_in <= pad0_data_in + 16'h3a71;
         pad1_data_in <= ~pad0_data_in;
      end
   end
endmodule // ebpsb_far_model
`default_nettype wire

/* File: tb_ext_bus_pin_select_bank.sv */
// Self-checking bench for the pin select bank
`include "ebpsb_consts.svh"
`default_nettype none
module tb_ext_bus_pin_select_bank;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] ok_r = `EBPSB_RESP_OKAY;
   localparam logic [1:0] err_r = `EBPSB_RESP_SLVERR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic standby_reset = 1'b0;
   logic [`EBPSB_ADDR_W-1:0] awaddr = '0;
   logic [`EBPSB_ADDR_W-1:0] araddr = '0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, reloc;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] ctl_data_in, pad0_data_in, pad1_data_in;
   ebpsb_pkg::ebpsb_pins_t ctl_out, pad0_out, pad0_oe, pad1_out, pad1_oe;
   int n_errors = 0;
   int n_checks = 0;

   always #5 aclk = ~aclk;

   ebpsb_bank DUT (.aclk(aclk), .aresetn(aresetn),
      .standby_reset(standby_reset), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ctl_out(ctl_out),
      .ctl_data_in(ctl_data_in), .pin_relocation_select(reloc),
      .pad0_out(pad0_out), .pad0_oe(pad0_oe),
      .pad0_data_in(pad0_data_in), .pad1_out(pad1_out),
      .pad1_oe(pad1_oe), .pad1_data_in(pad1_data_in));

   ebpsb_far_model far (.aclk(aclk), .ctl_out(ctl_out),
      .pad0_data_in(pad0_data_in), .pad1_data_in(pad1_data_in));

   task automatic results();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hang();
      n_errors++;
      $display("BAD %0t no bus answer", $time);
      results();
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] s, input logic [1:0] er);
      int k;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (k == 50) hang();
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
      // Idle edge, so a following call never redrives a strobe in one step
      @(posedge aclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
         input logic [1:0] er);
      int k;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (k == 50) hang();
      rready <= 1'b0;
      chk(rdata, exp);
      chk({30'h0, rresp}, {30'h0, er});
      @(posedge aclk);
   endtask

   // Only the selected set may drive; the pad enables lag one more edge
   task automatic pins(input logic [31:0] e);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk({7'h0, pad0_oe}, e[25] ? 32'h0 : {7'h0, e[24:0]});
      chk({7'h0, pad1_oe}, e[25] ? {7'h0, e[24:0]} : 32'h0);
      chk({31'h0, reloc}, {31'h0, e[25]});
      @(posedge aclk);
   endtask

   task automatic pipe();
      ebpsb_pkg::ebpsb_pins_t c;
      logic [15:0] p;
      @(negedge aclk);
      c = ctl_out;
      p = reloc ? pad1_data_in : pad0_data_in;
      @(negedge aclk);
      chk({7'h0, pad0_out}, {7'h0, c});
      chk({7'h0, pad1_out}, {7'h0, c});
      chk({16'h0, ctl_data_in}, {16'h0, p});
      @(posedge aclk);
   endtask

   initial begin
      int i;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`EBPSB_OFS_ENB, 32'h0, ok_r);
      rd(`EBPSB_OFS_ENA, 32'h0, ok_r);
      pins(32'h0);
      pipe();
      wr(`EBPSB_OFS_ENB, 32'hffff_ffff, 4'hf, ok_r);
      rd(`EBPSB_OFS_ENB, 32'h03ff_ffff, ok_r);
      rd(`EBPSB_OFS_EFF, 32'h03ff_ffff, ok_r);
      pins(32'h03ff_ffff);
      pipe();
      // Walk one enable across every field, strobe up to data 15
      for (i = 0; i < 25; i++) begin
         wr(`EBPSB_OFS_ENB, 32'h1 << i, 4'hf, ok_r);
         rd(`EBPSB_OFS_ENB, 32'h1 << i, ok_r);
         pins(32'h1 << i);
      end
      pipe();
      wr(`EBPSB_OFS_ENB, 32'hffff_5aff, 4'h2, ok_r);
      rd(`EBPSB_OFS_ENB, 32'h0100_5a00, ok_r);
      wr(`EBPSB_OFS_ENA, 32'h2, 4'hf, ok_r);
      rd(`EBPSB_OFS_EFF, 32'h01fe_5a00, ok_r);
      pins(32'h01fe_5a00);
      wr(`EBPSB_OFS_ENA, 32'hffff_fffd, 4'hf, ok_r);
      rd(`EBPSB_OFS_ENA, 32'h1, ok_r);
      rd(`EBPSB_OFS_EFF, 32'h0101_fffe, ok_r);
      pins(32'h0101_fffe);
      standby_reset <= 1'b1;
      repeat (2) @(posedge aclk);
      standby_reset <= 1'b0;
      repeat (2) @(posedge aclk);
      rd(`EBPSB_OFS_ENB, 32'h0100_5a00, ok_r);
      rd(`EBPSB_OFS_ENA, 32'h1, ok_r);
      wr(`EBPSB_OFS_EFF, 32'hffff_ffff, 4'hf, err_r);
      wr(12'h00c, 32'hffff_ffff, 4'hf, err_r);
      rd(12'h00c, 32'h0, err_r);
      rd(`EBPSB_OFS_ENB, 32'h0100_5a00, ok_r);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`EBPSB_OFS_ENB, 32'h0, ok_r);
      rd(`EBPSB_OFS_EFF, 32'h0, ok_r);
      pins(32'h0);
      results();
   end
endmodule // tb_ext_bus_pin_select_bank
`default_nettype wire
